//--- dsc_status_crc.sv
// Bus-access status capture and in-line CRC configuration for a multi-channel DMA controller.
// Assumes beats and source words from the channel engine are synchronous to REF_CLK_IN.
//
// What this block does
// - Direction bit reads one after a read beat, zero after a write.
// - Three-bit field holds the channel of the latest beat.
// - Read-only register holds the full address of the latest beat.
// - Byte order 00 passes bytes unchanged; 01 reverses bytes in the word.
// - Code 10 swaps half-words; code 11 swaps bytes within each half-word.
// - Reorder enable sends reordered data of the CRC-routed selected channel to the destination; other words pass unaltered.
// - Checksum mode: reflect bit picks LSb-first or MSb-first processing.
// - LFSR mode: reflect bit picks LSb-first or MSb-first processing.
// - LFSR mode: length field is polynomial length minus one.
// - Checksum mode ignores the polynomial length field.
// - Kind select one picks IP checksum, zero picks LFSR CRC.
// - Route enable passes channel transfers through the CRC unit.
// - With reorder enabled, append cannot be set; no unaligned transfers.
// - Unimplemented bits read zero and ignore writes.
// - Append feeds source only to CRC and writes CRC at block end.
// - CRC unit serves only the channel named by the channel select.
// - Data register write seeds; read returns CRC with high bits zero.
// - Tap enable bits 31 to 1 choose XOR feedback or plain shift per stage; stage 0 always takes the feedback.
`timescale 1ns/1ps
`default_nettype none
module dsc_status_crc
    import dsc_pkg::*;
(
    input  wire logic                    REF_CLK_IN,
    input  wire logic                    RST_B_IN,
    input  wire logic [dsc_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input  wire logic                    AVS_READ_IN,
    input  wire logic                    AVS_WRITE_IN,
    input  wire logic [31:0]             AVS_WRITEDATA_IN,
    input  wire logic [3:0]              AVS_BYTEENABLE_IN,
    output logic      [31:0]             AVS_READDATA_OUT,
    output logic                         AVS_WAITREQUEST_OUT,
    input  wire dsc_pkg::dsc_beat_type   BEAT_IN,
    input  wire dsc_pkg::dsc_word_type   SRC_IN,
    input  wire logic                    BLOCK_DONE_IN,
    input  wire logic [2:0]              BLOCK_DONE_CH_IN,
    input  wire logic [31:0]             DEST_START_ADDRESS_IN,
    output dsc_pkg::dsc_word_type        DST_OUT,
    output dsc_pkg::dsc_append_type      APPEND_OUT
);
    import dsc_pkg::*;

    typedef struct packed {
        dsc_bus_state_type bus;
        logic [31:0]       rdata;
        dsc_crc_ctrl_type  ctrl;
        logic [31:0]       taps;
        logic              last_access_dir;
        logic [2:0]        last_active_channel;
        logic [31:0]       last_access_address;
        dsc_word_type      dst;
        dsc_append_type    app;
    } dsc_top_state_type;

    dsc_top_state_type s_q;
    dsc_top_state_type s_d;
    logic              req;
    logic              wr_take;
    logic [31:0]       wmask;
    logic [31:0]       reordered;
    logic [31:0]       crc_value;
    logic              src_on_crc;
    logic              seed_we;

    assign req     = AVS_READ_IN | AVS_WRITE_IN;
    assign wr_take = AVS_WRITE_IN && (s_q.bus == BUS_ANSWER);
    assign wmask   = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                      {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    assign seed_we = wr_take && (AVS_ADDRESS_IN == OFF_CRC_VALUE);
    assign src_on_crc = SRC_IN.valid && s_q.ctrl.crc_route_en
                        && (SRC_IN.channel == s_q.ctrl.crc_channel_sel);

    dsc_byte_reorder u_reorder (
        .order_in (s_q.ctrl.byte_order_sel),
        .word_in  (SRC_IN.data),
        .word_out (reordered)
    );

    dsc_crc_engine u_crc (
        .clk_in        (REF_CLK_IN),
        .rst_b_in      (RST_B_IN),
        .ctrl_in       (s_q.ctrl),
        .taps_in       (s_q.taps),
        .seed_we_in    (seed_we),
        .seed_in       (AVS_WRITEDATA_IN),
        .word_valid_in (src_on_crc),
        .word_in       (reordered),
        .value_out     (crc_value)
    );

    // The slave answers one cycle after a fresh request, so readdata is always registered.
    assign AVS_WAITREQUEST_OUT = req && (s_q.bus == BUS_IDLE);
    assign AVS_READDATA_OUT    = s_q.rdata;
    assign DST_OUT             = s_q.dst;
    assign APPEND_OUT          = s_q.app;

    always_comb
    begin
        logic [31:0] cw;
        cw  = ctrl_to_word(s_q.ctrl);
        s_d = s_q;

        // Bus handshake.
        case (s_q.bus)
            BUS_IDLE:
            begin
                if (req)
                begin
                    s_d.bus = BUS_ANSWER;
                    if (!AVS_READ_IN)
                    begin
                        s_d.rdata = WORD_RESET;
                    end
                    else if (AVS_ADDRESS_IN == OFF_BUS_STATUS)
                    begin
                        s_d.rdata = {28'h000_0000, s_q.last_access_dir, s_q.last_active_channel}
                                    & STAT_IMPL_MASK;
                    end
                    else if (AVS_ADDRESS_IN == OFF_LAST_ADDRESS)
                    begin
                        s_d.rdata = s_q.last_access_address;
                    end
                    else if (AVS_ADDRESS_IN == OFF_CRC_CONTROL)
                    begin
                        s_d.rdata = cw & CTRL_IMPL_MASK;
                    end
                    else if (AVS_ADDRESS_IN == OFF_CRC_VALUE)
                    begin
                        s_d.rdata = crc_value;
                    end
                    else if (AVS_ADDRESS_IN == OFF_CRC_TAPS)
                    begin
                        s_d.rdata = s_q.taps;
                    end
                    else
                    begin
                        s_d.rdata = WORD_RESET;
                    end
                end
            end
            default:
            begin
                s_d.bus = BUS_IDLE;
            end
        endcase

        // Register writes take effect at the edge where waitrequest is low.
        if (wr_take && (AVS_ADDRESS_IN == OFF_CRC_CONTROL))
        begin
            s_d.ctrl = word_to_ctrl((cw & ~wmask) | (AVS_WRITEDATA_IN & wmask));
            if (s_d.ctrl.write_reorder_en)
            begin
                s_d.ctrl.crc_append = 1'b0;
            end
        end
        else if (wr_take && (AVS_ADDRESS_IN == OFF_CRC_TAPS))
        begin
            s_d.taps = (s_q.taps & ~wmask) | (AVS_WRITEDATA_IN & wmask);
        end

        if (BEAT_IN.valid)
        begin
            s_d.last_access_dir     = BEAT_IN.is_read;
            s_d.last_active_channel = BEAT_IN.channel;
            s_d.last_access_address = BEAT_IN.addr;
        end

        s_d.dst.valid   = SRC_IN.valid && !(src_on_crc && s_q.ctrl.crc_append);
        s_d.dst.channel = SRC_IN.channel;
        s_d.dst.data    = (src_on_crc && s_q.ctrl.write_reorder_en) ? reordered : SRC_IN.data;

        s_d.app.valid = BLOCK_DONE_IN && s_q.ctrl.crc_route_en && s_q.ctrl.crc_append
                        && (BLOCK_DONE_CH_IN == s_q.ctrl.crc_channel_sel);
        s_d.app.addr  = DEST_START_ADDRESS_IN;
        s_d.app.data  = crc_value;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            s_q.bus                 <= BUS_IDLE;
            s_q.rdata               <= WORD_RESET;
            s_q.ctrl                <= word_to_ctrl(WORD_RESET);
            s_q.taps                <= WORD_RESET;
            s_q.last_access_dir     <= STAT_RESET[STAT_DIR_POS];
            s_q.last_active_channel <= STAT_RESET[STAT_CH_POS +: 3];
            s_q.last_access_address <= WORD_RESET;
            s_q.dst                 <= '0;
            s_q.app                 <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    AST_DIR_CAPTURE: assert property (BEAT_IN.valid |=> s_q.last_access_dir == $past(BEAT_IN.is_read))
        else $error("Direction bit does not follow the last beat.");

    AST_CH_CAPTURE: assert property (BEAT_IN.valid |=> s_q.last_active_channel == $past(BEAT_IN.channel))
        else $error("Channel field does not follow the last beat.");

    AST_ADDR_CAPTURE: assert property (BEAT_IN.valid |=> s_q.last_access_address == $past(BEAT_IN.addr))
        else $error("Address register does not follow the last beat.");

    AST_STATUS_HOLD: assert property (!BEAT_IN.valid |=> $stable(s_q.last_access_address)
        && $stable(s_q.last_active_channel) && $stable(s_q.last_access_dir))
        else $error("Status changed without a beat.");

    AST_PLAIN_DEST: assert property (SRC_IN.valid && !(src_on_crc && s_q.ctrl.write_reorder_en)
        |=> DST_OUT.data == $past(SRC_IN.data))
        else $error("Destination data altered without reordering.");

    AST_WORD_SWAP: assert property (src_on_crc && s_q.ctrl.write_reorder_en
        && s_q.ctrl.byte_order_sel == BO_WORD_SWAP
        |=> DST_OUT.data == {$past(SRC_IN.data[7:0]), $past(SRC_IN.data[15:8]),
                             $past(SRC_IN.data[23:16]), $past(SRC_IN.data[31:24])})
        else $error("Word byte reversal wrong.");

    AST_APPEND_DROP: assert property (src_on_crc && s_q.ctrl.crc_append |=> !DST_OUT.valid)
        else $error("Destination written in append mode.");

    AST_NO_APPEND_WBO: assert property (s_q.ctrl.write_reorder_en |-> !s_q.ctrl.crc_append)
        else $error("Append set while reordering is enabled.");

    AST_CTRL_ZERO: assert property (s_q.bus == BUS_ANSWER && AVS_READ_IN
        && AVS_ADDRESS_IN == OFF_CRC_CONTROL |-> (AVS_READDATA_OUT & ~CTRL_IMPL_MASK) == WORD_RESET)
        else $error("Unimplemented control bits read non-zero.");

    AST_BUS_ANSWER: assert property ($rose(req) && s_q.bus == BUS_IDLE
        |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
        else $error("Slave did not answer one cycle after the request.");

    AST_HALF_SWAP: assert property (src_on_crc && s_q.ctrl.write_reorder_en
        && s_q.ctrl.byte_order_sel == BO_HALF_SWAP
        |=> DST_OUT.data == {$past(SRC_IN.data[15:0]), $past(SRC_IN.data[31:16])})
        else $error("Half swap wrong.");

    AST_OTHER_CH: assert property (SRC_IN.valid && SRC_IN.channel != s_q.ctrl.crc_channel_sel
        |=> DST_OUT.valid
        && DST_OUT.data == $past(SRC_IN.data))
        else $error("Other channel altered.");

    AST_ROUTE_OFF: assert property (SRC_IN.valid && !s_q.ctrl.crc_route_en
        |=> DST_OUT.valid
        && DST_OUT.data == $past(SRC_IN.data))
        else $error("Routed off but altered.");

    AST_APPEND_PULSE: assert property (BLOCK_DONE_IN && s_q.ctrl.crc_append
        && s_q.ctrl.crc_route_en && BLOCK_DONE_CH_IN == s_q.ctrl.crc_channel_sel
        |=> APPEND_OUT.valid && APPEND_OUT.addr == $past(DEST_START_ADDRESS_IN))
        else $error("No result at block end.");

    AST_APPEND_QUIET: assert property (!BLOCK_DONE_IN
        |=> !APPEND_OUT.valid)
        else $error("Stray result.");

    AST_STAT_ZERO: assert property (s_q.bus == BUS_ANSWER && AVS_READ_IN
        && AVS_ADDRESS_IN == OFF_BUS_STATUS
        |-> (AVS_READDATA_OUT & ~STAT_IMPL_MASK) == WORD_RESET)
        else $error("Status spare bits set.");

    AST_SUM_HIGH: assert property (s_q.ctrl.crc_kind_sel
        |-> crc_value[31:16] == 16'h0000)
        else $error("Checksum high half set.");

    // Two shifts keep a full-length field from wrapping the shift amount.
    AST_LEN_MASK: assert property (!s_q.ctrl.crc_kind_sel
        |-> ((crc_value >> s_q.ctrl.poly_length_m1) >> 1) == WORD_RESET)
        else $error("Bits above length set.");

    AST_DST_QUIET: assert property (!SRC_IN.valid |=> !DST_OUT.valid)
        else $error("Stray destination word.");

endmodule : dsc_status_crc
`default_nettype wire

//--- dsc_pkg.sv
// Shared constants, register map and carrier types for the DMA status and CRC configuration block.
// Assumes a single 50 MHz clock domain and a synchronous active-low reset in every user.
package dsc_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFF_BUS_STATUS   = 5'h00;
    localparam logic [4:0] OFF_LAST_ADDRESS = 5'h04;
    localparam logic [4:0] OFF_CRC_CONTROL  = 5'h08;
    localparam logic [4:0] OFF_CRC_VALUE    = 5'h0C;
    localparam logic [4:0] OFF_CRC_TAPS     = 5'h10;

    // Field positions.
    localparam int unsigned STAT_DIR_POS  = 3;
    localparam int unsigned STAT_CH_POS   = 0;
    localparam int unsigned CTRL_BYTE_ORDER_SEL_POS = 28;
    localparam int unsigned CTRL_WBO_POS  = 27;
    localparam int unsigned CTRL_BIT_REFLECT_POS = 24;
    localparam int unsigned CTRL_POLY_LENGTH_M1_POS = 8;
    localparam int unsigned CTRL_EN_POS   = 7;
    localparam int unsigned CTRL_APP_POS  = 6;
    localparam int unsigned CTRL_TYP_POS  = 5;
    localparam int unsigned CTRL_CH_POS   = 0;

    // Implemented bits of the control and status registers; all others read as zero.
    localparam logic [31:0] CTRL_IMPL_MASK = 32'h3900_1FE7;
    localparam logic [31:0] STAT_IMPL_MASK = 32'h0000_000F;

    // Reset values.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [3:0]  STAT_RESET = 4'h0;

    // Byte order codes.
    localparam logic [1:0] BO_NONE      = 2'h0;
    localparam logic [1:0] BO_WORD_SWAP = 2'h1;
    localparam logic [1:0] BO_HALF_SWAP = 2'h2;
    localparam logic [1:0] BO_HALF_BYTE = 2'h3;

    // Number of cycles the slave holds waitrequest on a fresh request.
    localparam int unsigned BUS_WAIT_CYCLES = 1;

    typedef enum logic {BUS_IDLE, BUS_ANSWER} dsc_bus_state_type;

    typedef struct packed {
        logic [1:0] byte_order_sel;
        logic       write_reorder_en;
        logic       bit_reflect;
        logic [4:0] poly_length_m1;
        logic       crc_route_en;
        logic       crc_append;
        logic       crc_kind_sel;
        logic [2:0] crc_channel_sel;
    } dsc_crc_ctrl_type;

    typedef struct packed {
        logic        valid;
        logic        is_read;
        logic [2:0]  channel;
        logic [31:0] addr;
    } dsc_beat_type;

    typedef struct packed {
        logic        valid;
        logic [2:0]  channel;
        logic [31:0] data;
    } dsc_word_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
    } dsc_append_type;

    function automatic logic [31:0] ctrl_to_word(input dsc_crc_ctrl_type c);
        logic [31:0] w;
        w = WORD_RESET;
        w[CTRL_BYTE_ORDER_SEL_POS +: 2] = c.byte_order_sel;
        w[CTRL_WBO_POS]       = c.write_reorder_en;
        w[CTRL_BIT_REFLECT_POS]      = c.bit_reflect;
        w[CTRL_POLY_LENGTH_M1_POS +: 5] = c.poly_length_m1;
        w[CTRL_EN_POS]        = c.crc_route_en;
        w[CTRL_APP_POS]       = c.crc_append;
        w[CTRL_TYP_POS]       = c.crc_kind_sel;
        w[CTRL_CH_POS +: 3]   = c.crc_channel_sel;
        return w;
    endfunction : ctrl_to_word

    function automatic dsc_crc_ctrl_type word_to_ctrl(input logic [31:0] w);
        dsc_crc_ctrl_type c;
        c.byte_order_sel   = w[CTRL_BYTE_ORDER_SEL_POS +: 2];
        c.write_reorder_en = w[CTRL_WBO_POS];
        c.bit_reflect      = w[CTRL_BIT_REFLECT_POS];
        c.poly_length_m1   = w[CTRL_POLY_LENGTH_M1_POS +: 5];
        c.crc_route_en     = w[CTRL_EN_POS];
        c.crc_append       = w[CTRL_APP_POS];
        c.crc_kind_sel     = w[CTRL_TYP_POS];
        c.crc_channel_sel  = w[CTRL_CH_POS +: 3];
        return c;
    endfunction : word_to_ctrl

endpackage : dsc_pkg

//--- dsc_byte_reorder.sv
// Byte reordering network applied to a 32-bit source word.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dsc_byte_reorder
    import dsc_pkg::*;
(
    input  wire logic [1:0]  order_in,
    input  wire logic [31:0] word_in,
    output logic      [31:0] word_out
);
    always_comb
    begin
        case (order_in)
            BO_WORD_SWAP: word_out = {word_in[7:0], word_in[15:8], word_in[23:16], word_in[31:24]};
            BO_HALF_SWAP: word_out = {word_in[15:0], word_in[31:16]};
            BO_HALF_BYTE: word_out = {word_in[23:16], word_in[31:24], word_in[7:0], word_in[15:8]};
            default:      word_out = word_in;
        endcase
    end
endmodule : dsc_byte_reorder
`default_nettype wire

//--- dsc_crc_engine.sv
// CRC generator: programmable LFSR with per-stage feedback enables, or 16-bit IP header checksum.
// Assumes words arrive already byte-reordered and at most one per clock.
`timescale 1ns/1ps
`default_nettype none
module dsc_crc_engine
    import dsc_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire dsc_crc_ctrl_type ctrl_in,
    input  wire logic [31:0]      taps_in,
    input  wire logic             seed_we_in,
    input  wire logic [31:0]      seed_in,
    input  wire logic             word_valid_in,
    input  wire logic [31:0]      word_in,
    output logic      [31:0]      value_out
);
    typedef struct packed {
        logic [31:0] crc;
    } dsc_crc_state_type;

    dsc_crc_state_type s_q;
    dsc_crc_state_type s_d;
    logic [31:0]       len_mask;

    // One LFSR shift; a stage with its enable clear just takes the previous stage.
    function automatic logic [31:0] lfsr_step(input logic [31:0] c, input logic b,
                                              input logic [31:0] taps, input logic [4:0] msb);
        logic        fb;
        logic [31:0] n;
        fb = c[msb] ^ b;
        n  = {c[30:0], fb};
        for (int i = 1; i < 32; i++)
        begin
            n[i] = c[i - 1] ^ (taps[i] & fb);
        end
        return n;
    endfunction : lfsr_step

    // Ones-complement add of one half-word into the running sum.
    function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[15:0] + {15'h0000, t[16]};
    endfunction : ones_add

    function automatic logic [15:0] flip16(input logic [15:0] h);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = h[15 - i];
        end
        return r;
    endfunction : flip16

    always_comb
    begin
        len_mask = 32'hFFFF_FFFF >> (5'd31 - ctrl_in.poly_length_m1);
    end

    always_comb
    begin
        logic [31:0] c;
        logic [15:0] hi;
        logic [15:0] lo;
        c    = s_q.crc;
        hi   = word_in[31:16];
        lo   = word_in[15:0];
        s_d  = s_q;
        if (seed_we_in)
        begin
            // The checksum is kept as a plain sum, so a seed is stored complemented.
            s_d.crc = ctrl_in.crc_kind_sel ? {16'h0000, ~seed_in[15:0]} : (seed_in & len_mask);
        end
        else if (word_valid_in)
        begin
            if (ctrl_in.crc_kind_sel)
            begin
                if (ctrl_in.bit_reflect)
                begin
                    hi = flip16(hi);
                    lo = flip16(lo);
                end
                s_d.crc = {16'h0000, ones_add(ones_add(c[15:0], hi), lo)};
            end
            else
            begin
                for (int i = 0; i < 32; i++)
                begin
                    c = lfsr_step(c, ctrl_in.bit_reflect ? word_in[i] : word_in[31 - i],
                                  taps_in, ctrl_in.poly_length_m1);
                end
                s_d.crc = c & len_mask;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            s_q.crc <= WORD_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign value_out = ctrl_in.crc_kind_sel ? {16'h0000, ~s_q.crc[15:0]} : (s_q.crc & len_mask);

endmodule : dsc_crc_engine
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the DMA status and CRC configuration block.
// Assumes dsc_pkg and the design files compile first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dsc_pkg::*;
;
    logic           clk, rst_b, rd, wr, bdone, wreq;
    logic [4:0]     adr, pl;
    logic [3:0]     be;
    logic [2:0]     bch, c;
    logic [31:0]    wd, rdat, dsa, d, s, tp, m;
    logic [15:0]    cs;
    dsc_beat_type   beat, bt;
    dsc_word_type   src, dst, xd[$];
    dsc_append_type app, xa[$];
    logic [31:0]    xr[$];
    logic [31:0]    ctl[6] = '{32'h0800_0080, 32'h1800_0080, 32'h2800_0080, 32'h3800_0080, 32'h1000_0080,
                               32'h1800_0000};
    int             error_cnt = 0, checked = 0, seed = 32'h7b5f_080c;

    dsc_status_crc DUT (
        .REF_CLK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
        .BEAT_IN(beat), .SRC_IN(src), .BLOCK_DONE_IN(bdone), .BLOCK_DONE_CH_IN(bch),
        .DEST_START_ADDRESS_IN(dsa), .DST_OUT(dst), .APPEND_OUT(app)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rd(input logic [31:0] g, e);
        chk(96'(g), 96'(e));
    endtask : chk_rd

    task automatic chk_dst(input dsc_word_type g, e);
        chk(96'(g), 96'(e));
    endtask : chk_dst

    task automatic chk_app(input dsc_append_type g, e);
        chk(96'(g), 96'(e));
    endtask : chk_app

    // Holds the request until waitrequest is seen low; a stuck slave ends the run.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        int n;
        n = 0;
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= v;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0)
        begin
            chk(96'(wreq), 96'h0);
            conclude();
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        xr.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rdc

    task automatic put(input logic [2:0] ch, input logic e, input logic [31:0] x);
        src <= {1'b1, ch, d};
        if (e)
            xd.push_back({1'b1, ch, x});
        @(posedge clk);
    endtask : put

    function automatic logic [31:0] reo(input logic [31:0] w, input logic [31:0] v);
        case (w[29:28])
            2'h1: return {v[7:0], v[15:8], v[23:16], v[31:24]};
            2'h2: return {v[15:0], v[31:16]};
            2'h3: return {v[23:16], v[31:24], v[7:0], v[15:8]};
            default: return v;
        endcase
    endfunction : reo

    function automatic logic [15:0] cks(input logic [15:0] a, input logic [31:0] w, input logic r);
        logic [16:0] t;
        logic [15:0] h;
        for (int k = 0; k < 2; k++)
        begin
            h = k ? w[15:0] : w[31:16];
            if (r)
                h = {<<{h}};
            t = a + h;
            a = t[15:0] + t[16];
        end
        return a;
    endfunction : cks

    function automatic logic [31:0] lfsr(input logic [31:0] st, input logic r);
        logic fb;
        for (int k = 0; k < 32; k++)
        begin
            fb = st[pl] ^ (r ? d[k] : d[31-k]);
            st = {st[30:0], 1'b0} ^ (tp & {32{fb}});
            st[0] = fb;
        end
        return st;
    endfunction : lfsr

    // Results are sampled before the edge's own updates land, so each is seen in the cycle it stands.
    always @(posedge clk)
    begin
        if (rst_b === 1'b1 && rd === 1'b1 && wreq === 1'b0)
            chk_rd(rdat, xr.size() != 0 ? xr.pop_front() : 'x); // register read
        if (rst_b === 1'b1 && dst.valid !== 1'b0)
            chk_dst(dst, xd.size() != 0 ? xd.pop_front() : 'x); // destination word
        if (rst_b === 1'b1 && app.valid !== 1'b0)
            chk_app(app, xa.size() != 0 ? xa.pop_front() : 'x); // appended result
    end

    initial
    begin
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = '0;
        wd = '0;
        be = 4'hF;
        beat = '0;
        src = '0;
        bdone = 1'b0;
        bch = '0;
        dsa = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++)
            rdc(5'(4 * k), 32'h0000_0000); // reset and unmapped zero
        for (int k = 0; k < 4; k++)
        begin
            repeat (2)
            begin
                bt = dsc_beat_type'(37'({$random(seed), $random(seed)}));
                bt.valid = 1'b1;
                bt.is_read = k[0];
                beat <= bt;
                @(posedge clk);
            end
            beat <= '0;
            rdc(OFF_BUS_STATUS, {28'h000_0000, bt.is_read, bt.channel}); // status
            rdc(OFF_LAST_ADDRESS, bt.addr); // last address
        end
        bus(1'b1, OFF_BUS_STATUS, 32'hFFFF_FFFF);
        rdc(OFF_BUS_STATUS, {28'h000_0000, bt.is_read, bt.channel}); // read-only status
        bus(1'b1, OFF_CRC_CONTROL, 32'hFFFF_FFFF);
        rdc(OFF_CRC_CONTROL, CTRL_IMPL_MASK & 32'hFFFF_FFBF); // append refused
        bus(1'b1, OFF_CRC_CONTROL, 32'hF7FF_FFFF);
        rdc(OFF_CRC_CONTROL, CTRL_IMPL_MASK & 32'hF7FF_FFFF); // unused bits zero
        be <= 4'h1;
        bus(1'b1, OFF_CRC_CONTROL, 32'h0000_0000);
        be <= 4'hF;
        rdc(OFF_CRC_CONTROL, CTRL_IMPL_MASK & 32'hF7FF_FF00); // byte lanes
        for (int k = 0; k < 6; k++)
        begin
            c = 3'($random(seed));
            d = $random(seed);
            bus(1'b1, OFF_CRC_CONTROL, ctl[k] | c);
            put(c, 1'b1, (ctl[k][27] & ctl[k][7]) ? reo(ctl[k], d) : d); // order
            put(c + 3'h1, 1'b1, d); // other channel untouched
            src <= '0;
        end
        for (int r = 0; r < 2; r++)
        begin
            c = 3'($random(seed));
            s = $random(seed);
            bus(1'b1, OFF_CRC_CONTROL, {7'h0, 1'(r), 11'h0, 5'($random(seed)), 8'hA0 | c});
            bus(1'b1, OFF_CRC_VALUE, s);
            rdc(OFF_CRC_VALUE, {16'h0000, s[15:0]}); // seed readback
            cs = ~s[15:0];
            repeat (2)
            begin
                d = $random(seed);
                cs = cks(cs, d, 1'(r));
                put(c, 1'b1, d);
            end
            src <= '0;
            rdc(OFF_CRC_VALUE, {16'h0000, ~cs}); // checksum
        end
        for (int r = 0; r < 2; r++)
        begin
            c = 3'($random(seed));
            pl = r ? 5'h1F : 5'($random(seed));
            m = 32'hFFFF_FFFF >> (5'h1F - pl);
            tp = $random(seed);
            s = $random(seed);
            d = $random(seed);
            bus(1'b1, OFF_CRC_TAPS, tp);
            bus(1'b1, OFF_CRC_CONTROL, {7'h0, 1'(r), 11'h0, pl, 8'h80 | c});
            bus(1'b1, OFF_CRC_VALUE, s);
            rdc(OFF_CRC_TAPS, tp); // tap readback
            rdc(OFF_CRC_VALUE, s & m); // seed masked
            put(c, 1'b1, d);
            src <= '0;
            rdc(OFF_CRC_VALUE, lfsr(s, 1'(r)) & m); // shift register
        end
        c = 3'($random(seed));
        s = $random(seed);
        d = $random(seed);
        bus(1'b1, OFF_CRC_CONTROL, 32'h0000_00E0 | c);
        bus(1'b1, OFF_CRC_VALUE, s);
        cs = cks(~s[15:0], d, 1'b0);
        put(c, 1'b0, d); // source kept from destination
        put(c + 3'h1, 1'b1, d); // unselected channel passes
        src <= '0;
        bdone <= 1'b1;
        bch <= c + 3'h1;
        dsa <= ~d;
        @(posedge clk);
        bch <= c;
        dsa <= d;
        xa.push_back({1'b1, d, 16'h0000, ~cs});
        @(posedge clk);
        bdone <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(xr.size() + xd.size() + xa.size()), 96'h0); // every result seen
        conclude();
    end
endmodule : tb_top
`default_nettype wire
